// *** hdl/scib_pkg.sv ***
// constants, register map and carrier types of the statistics counter
// bank with its top-level interrupt tree; one 40 MHz clock is assumed.
//
// How it works
// - 144 counters, 24 bits, zero at reset
// - count events, wrap at all ones, flag overflow
// - overflow raises a request, one mask per counter
// - sixteen input ports, four counters each
// - input HEC counter skips corrected headers
// - sixteen transmit links, two counters each
// - sixteen receive links, three, count when enabled
// - select, read command, value lands in holding
// - holding copy stays until next read
// - holding, select, write command loads counter
// - enable and disable codes set counter mask
// - latch snapshots all counters, pin or software
// - pin events used directly or divided 8000
// - counters 24 bits, 16 when latching
// - counters restart after every latch event, at one if an event coincides
// - sources enableable, cleared only by host write
// - master status: one bit per link
// - interrupt pin low when enabled status active
// - master status combinational from link status
// - master bit drops when source or enable cleared
// - master status access changes no state
// - ready bit set when transfer completes
// - link status bit0: enabled counter overflow

package scib_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_CNT  = 144;
  localparam int CNT_W    = 24;
  localparam int LATCH_W  = 16;
  localparam int NUM_LINK = 16;
  localparam int ADDR_W   = 11;
  localparam int DATA_W   = 16;
  localparam int SEL_W    = 8;
  localparam int UTO_PER  = 4;
  localparam int TX_PER   = 2;
  localparam int RX_PER   = 3;
  localparam int UTO_BASE = 0;
  localparam int TX_BASE  = 64;
  localparam int RX_BASE  = 96;
  localparam logic [SEL_W-1:0] SEL_LIMIT = 8'h90;

  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_XFER_CMD = 11'h40F;
  localparam logic [ADDR_W-1:0] ADDR_HOLD_HI  = 11'h430;
  localparam logic [ADDR_W-1:0] ADDR_HOLD_LO  = 11'h431;
  localparam logic [ADDR_W-1:0] ADDR_SEL      = 11'h432;
  localparam logic [ADDR_W-1:0] ADDR_MEN      = 11'h433;
  localparam logic [ADDR_W-1:0] ADDR_MSTAT    = 11'h455;

  // ==========================================================
  // transfer command fields
  localparam int CMD_OP_LSB    = 0;
  localparam int CMD_IRQ_BIT   = 3;
  localparam int CMD_ZERO_BIT  = 4;
  localparam int CMD_LEN_BIT   = 8;
  localparam int CMD_LPIN_BIT  = 9;
  localparam int CMD_LDIV_BIT  = 10;
  localparam int CMD_LSW_BIT   = 11;
  localparam int CMD_READY_BIT = 15;
  localparam logic [2:0] OP_READ  = 3'h5;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_IRQ   = 3'h2;

  // ==========================================================
  // reset values and counts
  localparam logic [DATA_W-1:0] RST_HOLD = 16'h0000;
  localparam logic [SEL_W-1:0]  RST_SEL  = 8'h00;
  localparam logic [NUM_LINK-1:0] RST_MEN = 16'h0000;
  localparam logic [CNT_W-1:0]  RST_CNT  = 24'h000000;
  localparam int  LATCH_DIV = 8000;
  localparam int  DIV_W     = 13;
  localparam logic [DIV_W-1:0] DIV_LAST = 13'(LATCH_DIV - 1);

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } scib_host_req_t;

endpackage : scib_pkg

// *** hdl/scib_top.sv ***
// statistics counter bank with indirect host access and the
// master interrupt tree. host strobes are on clk_i; event pulses
// come from logic on clk_i; the latch pin is asynchronous.
`timescale 1ns/100ps
`default_nettype none

module scib_top
  import scib_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rstn_i,
  // host register port
  input  wire scib_host_req_t       host_i,
  output logic [DATA_W-1:0]         rdata_o,
  // latch pin
  input  wire logic                 frame_pulse_8khz_i,
  // counted events, one-cycle pulses
  input  wire logic [63:0]          utopia_evt_i,
  input  wire logic [NUM_LINK-1:0]  utopia_hec_corr_i,
  input  wire logic [31:0]          tx_evt_i,
  input  wire logic [47:0]          rx_evt_i,
  input  wire logic [NUM_LINK-1:0]  rx_hec_corr_i,
  input  wire logic [NUM_LINK-1:0]  rx_port_en_i,
  // interrupt tree
  input  wire logic [NUM_LINK-1:0]  link_src_i,
  output logic [NUM_LINK-1:0]       link_ovf_o,
  output logic                      irq_n_o
);

  // ==========================================================
  // storage
  logic [CNT_W-1:0]   cnt_reg  [NUM_CNT];
  logic [LATCH_W-1:0] snap_reg [NUM_CNT];
  logic [NUM_CNT-1:0] ovf_reg;
  logic [NUM_CNT-1:0] irq_en_reg;
  logic [NUM_CNT-1:0] evt;
  logic [7:0]          hold_hi_reg;
  logic [DATA_W-1:0]   hold_lo_reg;
  logic [SEL_W-1:0]    sel_reg;
  logic [NUM_LINK-1:0] men_reg;
  logic                latch_en_reg;
  logic                latch_pin_reg;
  logic                latch_div_reg;
  logic                ready_reg;
  logic                pend_rd_reg;
  logic                pend_wr_reg;
  logic                sw_trig_reg;
  logic [DATA_W-1:0]   rdata_reg;
  logic [2:0]          pin_sync_reg;
  logic [DIV_W-1:0]    div_cnt_reg;
  logic                pin_rise;
  logic                div_tick;
  logic                latch_evt;
  logic                cmd_wr;
  logic                sel_ok;
  logic [NUM_LINK-1:0] mstat;
  logic [DATA_W-1:0]   rd_mux;
  logic [CNT_W-1:0]    cnt_sel_val;
  logic [LATCH_W-1:0]  snap_sel_val;
  logic                irq_sel_val;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // ==========================================================
  // event map
  // a corrected header is a good cell, so it is not an error count
  genvar gl;
  generate
    for (gl = 0; gl < NUM_LINK; gl++)
    begin : g_evt
      assign evt[UTO_BASE+gl*UTO_PER +: UTO_PER-1] =
        utopia_evt_i[gl*UTO_PER +: UTO_PER-1];
      assign evt[UTO_BASE+gl*UTO_PER+UTO_PER-1] =
        utopia_evt_i[gl*UTO_PER+UTO_PER-1]
        & ~utopia_hec_corr_i[gl];
      assign evt[TX_BASE+gl*TX_PER +: TX_PER] =
        tx_evt_i[gl*TX_PER +: TX_PER];
      assign evt[RX_BASE+gl*RX_PER +: RX_PER-1] =
        rx_evt_i[gl*RX_PER +: RX_PER-1] & {2{rx_port_en_i[gl]}};
      assign evt[RX_BASE+gl*RX_PER+RX_PER-1] =
        rx_evt_i[gl*RX_PER+RX_PER-1] & rx_port_en_i[gl]
        & ~rx_hec_corr_i[gl];
    end
  endgenerate

  // ==========================================================
  // host decode
  assign cmd_wr = host_i.wr && host_i.addr == ADDR_XFER_CMD
                  && !host_i.wdata[CMD_ZERO_BIT];
  assign sel_ok = sel_reg < SEL_LIMIT;
  // out-of-range selects read as zero and never write
  assign cnt_sel_val  = sel_ok ? cnt_reg[sel_reg] : RST_CNT;
  assign snap_sel_val = sel_ok ? snap_reg[sel_reg] : RST_CNT[15:0];
  assign irq_sel_val  = sel_ok ? irq_en_reg[sel_reg] : 1'b0;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sel_reg <= RST_SEL;
      men_reg <= RST_MEN;
    end
    else if (host_i.wr)
    begin
      if (host_i.addr == ADDR_SEL)
        sel_reg <= host_i.wdata[SEL_W-1:0];
      if (host_i.addr == ADDR_MEN)
        men_reg <= host_i.wdata[NUM_LINK-1:0];
    end
  end

  // ==========================================================
  // transfer command: config bits and pending transfer
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      latch_en_reg  <= 1'b0;
      latch_pin_reg <= 1'b0;
      latch_div_reg <= 1'b0;
      sw_trig_reg   <= 1'b0;
      pend_rd_reg   <= 1'b0;
      pend_wr_reg   <= 1'b0;
    end
    else
    begin
      sw_trig_reg <= 1'b0;
      pend_rd_reg <= 1'b0;
      pend_wr_reg <= 1'b0;
      if (host_i.wr && host_i.addr == ADDR_XFER_CMD)
      begin
        latch_en_reg  <= host_i.wdata[CMD_LEN_BIT];
        latch_pin_reg <= host_i.wdata[CMD_LPIN_BIT];
        latch_div_reg <= host_i.wdata[CMD_LDIV_BIT];
        sw_trig_reg   <= host_i.wdata[CMD_LSW_BIT];
      end
      if (cmd_wr)
      begin
        pend_rd_reg <= host_i.wdata[2:0] == OP_READ;
        pend_wr_reg <= host_i.wdata[2:0] == OP_WRITE;
      end
    end
  end

  // ready falls on a read or write command and rises once it is done;
  // completion wins over a new command in the same cycle
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ready_reg <= 1'b1;
    else if (pend_rd_reg || pend_wr_reg)
      ready_reg <= 1'b1;
    else if (cmd_wr && (host_i.wdata[2:0] == OP_READ
                        || host_i.wdata[2:0] == OP_WRITE))
      ready_reg <= 1'b0;
  end

  // ==========================================================
  // holding registers
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hold_hi_reg <= RST_HOLD[7:0];
      hold_lo_reg <= RST_HOLD;
    end
    else if (pend_rd_reg)
    begin
      // snapshot is the stable copy while latching is on
      if (latch_en_reg)
      begin
        hold_hi_reg <= 8'h00;
        hold_lo_reg <= snap_sel_val;
      end
      else
      begin
        hold_hi_reg <= cnt_sel_val[23:16];
        hold_lo_reg <= cnt_sel_val[15:0];
      end
    end
    else if (host_i.wr)
    begin
      // holding is only host-written otherwise, so a read copy stays
      if (host_i.addr == ADDR_HOLD_HI)
        hold_hi_reg <= host_i.wdata[7:0];
      if (host_i.addr == ADDR_HOLD_LO)
        hold_lo_reg <= host_i.wdata;
    end
  end

  // ==========================================================
  // latch trigger
  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pin_sync_reg <= 3'h0;
    else
      pin_sync_reg <= {pin_sync_reg[1:0], frame_pulse_8khz_i};
  end
  assign pin_rise = pin_sync_reg[1] & ~pin_sync_reg[2];

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      div_cnt_reg <= '0;
    else if (!(latch_en_reg && latch_pin_reg && latch_div_reg))
      div_cnt_reg <= '0;
    else if (pin_rise)
      div_cnt_reg <= (div_cnt_reg == DIV_LAST) ? '0
                     : div_cnt_reg + 13'h0001;
  end
  assign div_tick = pin_rise && div_cnt_reg == DIV_LAST;

  always_comb
  begin
    latch_evt = 1'b0;
    if (latch_en_reg)
    begin
      if (!latch_pin_reg)
        latch_evt = sw_trig_reg;
      else if (latch_div_reg)
        latch_evt = div_tick;
      else
        latch_evt = pin_rise;
    end
  end

  // ==========================================================
  // counter bank
  // an event in the latch cycle counts in the new interval
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < NUM_CNT; i++)
      begin
        cnt_reg[i]  <= RST_CNT;
        snap_reg[i] <= RST_CNT[15:0];
      end
      ovf_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_CNT; i++)
      begin
        if (latch_evt)
        begin
          snap_reg[i] <= cnt_reg[i][15:0];
          cnt_reg[i]  <= {23'h000000, evt[i]};
        end
        else if (pend_wr_reg && sel_reg == 8'(i))
        begin
          // a preload also clears the counter's overflow
          cnt_reg[i] <= {hold_hi_reg, hold_lo_reg};
          ovf_reg[i] <= 1'b0;
        end
        else if (evt[i])
        begin
          if (latch_en_reg ? cnt_reg[i][15:0] == 16'hFFFF
                           : cnt_reg[i] == 24'hFFFFFF)
          begin
            cnt_reg[i] <= RST_CNT;
            ovf_reg[i] <= 1'b1;
          end
          else
            cnt_reg[i] <= cnt_reg[i] + 24'h000001;
        end
      end
    end
  end

  // per-counter interrupt mask, masked from reset
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      irq_en_reg <= '0;
    else if (cmd_wr && host_i.wdata[2:0] == OP_IRQ && sel_ok)
      irq_en_reg[sel_reg] <= host_i.wdata[CMD_IRQ_BIT];
  end

  // ==========================================================
  // interrupt tree, purely combinational so no clear is needed here
  generate
    for (gl = 0; gl < NUM_LINK; gl++)
    begin : g_link
      localparam int U = UTO_BASE + gl*UTO_PER;
      localparam int T = TX_BASE + gl*TX_PER;
      localparam int R = RX_BASE + gl*RX_PER;
      assign link_ovf_o[gl] =
          |(ovf_reg[U +: UTO_PER] & irq_en_reg[U +: UTO_PER])
        | |(ovf_reg[T +: TX_PER]  & irq_en_reg[T +: TX_PER])
        | |(ovf_reg[R +: RX_PER]  & irq_en_reg[R +: RX_PER]);
    end
  endgenerate

  assign mstat   = link_ovf_o | link_src_i;
  assign irq_n_o = ~|(mstat & men_reg);

  // ==========================================================
  // read port, one cycle latency; master status read is side-free
  always_comb
  begin
    rd_mux = '0;
    unique case (host_i.addr)
      ADDR_XFER_CMD:
        rd_mux = {ready_reg, 4'h0, latch_div_reg, latch_pin_reg,
                  latch_en_reg, 8'h00};
      ADDR_HOLD_HI: rd_mux = {8'h00, hold_hi_reg};
      ADDR_HOLD_LO: rd_mux = hold_lo_reg;
      ADDR_SEL:     rd_mux = {8'h00, sel_reg};
      ADDR_MEN:     rd_mux = men_reg;
      ADDR_MSTAT:   rd_mux = mstat;
      default:      rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_reg <= '0;
    else if (host_i.rd)
      rdata_reg <= rd_mux;
  end
  assign rdata_o = rdata_reg;

  // ==========================================================
  // checks
  read_copy_a: assert property (
    pend_rd_reg && sel_ok && !latch_en_reg && !latch_evt && !evt[0]
    |=> hold_lo_reg == $past(cnt_sel_val[15:0])
        && hold_hi_reg == $past(cnt_sel_val[23:16]))
    else $error("read command did not copy counter to holding");

  hold_keep_a: assert property (
    !pend_rd_reg && !(host_i.wr && (host_i.addr == ADDR_HOLD_HI
                                   || host_i.addr == ADDR_HOLD_LO))
    |=> $stable(hold_lo_reg) && $stable(hold_hi_reg))
    else $error("holding copy changed without a read command");

  preload_a: assert property (
    pend_wr_reg && sel_ok && !latch_evt
    |=> $past(sel_reg) != sel_reg
        || cnt_sel_val == $past({hold_hi_reg, hold_lo_reg}))
    else $error("write command did not load selected counter");

  irq_mask_a: assert property (
    cmd_wr && host_i.wdata[2:0] == OP_IRQ && sel_ok
    |=> $past(sel_reg) != sel_reg
        || irq_sel_val == $past(host_i.wdata[CMD_IRQ_BIT]))
    else $error("mask command did not reach selected counter");

  ready_seq_a: assert property (
    cmd_wr && host_i.wdata[2:0] == OP_READ
    && !pend_rd_reg && !pend_wr_reg
    |=> !ready_reg && pend_rd_reg ##1 ready_reg)
    else $error("ready did not fall then rise after a read");

  latch_zero_a: assert property (
    latch_evt |=> cnt_reg[0] == {23'h000000, $past(evt[0])}
                  && snap_reg[0] == $past(cnt_reg[0][15:0]))
    else $error("latch did not snapshot and clear counter 0");

  wrap_a: assert property (
    evt[0] && !latch_evt && !latch_en_reg && cnt_reg[0] == 24'hFFFFFF
    && !(pend_wr_reg && sel_reg == 8'h00)
    |=> cnt_reg[0] == RST_CNT && ovf_reg[0])
    else $error("counter 0 did not wrap with overflow");

  wrap16_a: assert property (
    evt[4] && !latch_evt && latch_en_reg && cnt_reg[4][15:0] == 16'hFFFF
    && !(pend_wr_reg && sel_reg == 8'h04)
    |=> cnt_reg[4] == RST_CNT && ovf_reg[4])
    else $error("counter 4 did not wrap at 16 bits while latching");

  rx_gate_a: assert property (
    !rx_port_en_i[0] && !latch_evt && !(pend_wr_reg && sel_reg == 8'h60)
    |=> $stable(cnt_reg[RX_BASE]))
    else $error("receive counter moved while port disabled");

  div_range_a: assert property (
    div_tick |-> latch_en_reg && latch_pin_reg && latch_div_reg
                 ##1 div_cnt_reg == '0)
    else $error("divide-by tick out of place");

  one_edge_a: assert property (
    pin_rise |=> !pin_rise)
    else $error("one pin pulse gave two latch edges");

  irq_drop_a: assert property (
    host_i.wr && host_i.addr == ADDR_MEN && host_i.wdata == 16'h0000
    |=> irq_n_o)
    else $error("interrupt pin still low after enables cleared");

  mstat_read_a: assert property (
    host_i.rd && host_i.addr == ADDR_MSTAT && !host_i.wr
    |=> $stable(men_reg) && $stable(irq_en_reg) && $stable(sel_reg))
    else $error("master status read changed state");

endmodule : scib_top

`default_nettype wire

// *** bench/scib_host_model.sv ***
// host processor model for the counter bank register port.
// assumes host strobes sampled on rising clk_i, data one edge later.
`timescale 1ns/100ps
`default_nettype none

module scib_host_model
  import scib_pkg::*;
(
  // clock
  input  wire logic              clk_i,
  // register port
  output var  scib_host_req_t    host_o,
  input  wire logic [DATA_W-1:0] rdata_i
);
  logic [DATA_W-1:0] cfg;

  initial
  begin
    host_o = '0;
    cfg = 16'h0000;
  end

  // ==========================================================
  // bus cycles
  // released address and data lines are inverted, not left valid
  task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] r);
    @(posedge clk_i);
    #2;
    host_o.wr = w;
    host_o.rd = !w;
    host_o.addr = a;
    host_o.wdata = d;
    @(posedge clk_i);
    #2;
    r = rdata_i;
    host_o.wr = 1'b0;
    host_o.rd = 1'b0;
    host_o.addr = ~a;
    host_o.wdata = ~d;
  endtask : access

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] r;
    access(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a,
                    output logic [DATA_W-1:0] r);
    access(1'b0, a, 16'h0000, r);
  endtask : rd

  // ==========================================================
  // counter transfers; config bits ride on every command
  task automatic cmd(input logic [DATA_W-1:0] op);
    logic [DATA_W-1:0] r;
    wr(ADDR_XFER_CMD, cfg | op);
    @(posedge clk_i);
    for (int i = 0; i < 8; i++)
    begin
      rd(ADDR_XFER_CMD, r);
      if (r[CMD_READY_BIT])
        break;
    end
  endtask : cmd

  task automatic cnt_read(input int idx, output logic [CNT_W-1:0] v);
    logic [DATA_W-1:0] lo;
    logic [DATA_W-1:0] hi;
    wr(ADDR_SEL, 16'(idx));
    cmd(16'(OP_READ));
    rd(ADDR_HOLD_LO, lo);
    rd(ADDR_HOLD_HI, hi);
    v = {hi[7:0], lo};
  endtask : cnt_read

  // bench only preloads before latch mode is switched on
  task automatic cnt_load(input int idx, input logic [CNT_W-1:0] v);
    wr(ADDR_HOLD_HI, 16'(v[23:16]));
    wr(ADDR_HOLD_LO, v[15:0]);
    wr(ADDR_SEL, 16'(idx));
    cmd(16'(OP_WRITE));
  endtask : cnt_load

  task automatic mask(input int idx, input logic en);
    wr(ADDR_SEL, 16'(idx));
    wr(ADDR_XFER_CMD, cfg | 16'({en, OP_IRQ}));
  endtask : mask

  task automatic set_cfg(input logic [DATA_W-1:0] c);
    cfg = c;
    wr(ADDR_XFER_CMD, c | 16'h0010);
  endtask : set_cfg

  task automatic sw_latch();
    wr(ADDR_XFER_CMD, cfg | 16'h0810);
  endtask : sw_latch
endmodule : scib_host_model

`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench of the counter bank: reset values, a table of counter
// cases, then reset, hec, interrupt, hold and latch cases; host via the model.
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import scib_pkg::*;
;
  // ==========================================================
  // signals
  logic                clk;
  logic                rstn;
  scib_host_req_t      host_req;
  logic [DATA_W-1:0]   rdata;
  logic                pin;
  logic [63:0]         uto_evt;
  logic [NUM_LINK-1:0] uto_corr;
  logic [31:0]         tx_evt;
  logic [47:0]         rx_evt;
  logic [NUM_LINK-1:0] rx_corr;
  logic [NUM_LINK-1:0] rx_en;
  logic [NUM_LINK-1:0] src;
  logic [NUM_LINK-1:0] ovf;
  logic                irq_n;
  logic [DATA_W-1:0]   q;
  logic [CNT_W-1:0]    v;
  int                  miscompares;
  int                  num_checks;

  typedef struct {
    int               idx;
    logic [CNT_W-1:0] pre;
    int               n;
    logic [CNT_W-1:0] exp;
  } scib_row_t;

  scib_row_t rows [8] = '{
    '{0,   24'h000010, 3, 24'h000013},
    '{63,  24'hABCDEF, 0, 24'hABCDEF},
    '{64,  24'h000000, 5, 24'h000005},
    '{95,  24'h123456, 1, 24'h123457},
    '{96,  24'h000000, 2, 24'h000002},
    '{100, 24'hFFFFFF, 1, 24'h000000},
    '{143, 24'hFFFFFE, 1, 24'hFFFFFF},
    '{144, 24'h000055, 0, 24'h000000}
  };
  logic [ADDR_W-1:0] zero_regs [6] = '{ADDR_HOLD_HI, ADDR_HOLD_LO,
    ADDR_SEL, ADDR_MEN, ADDR_MSTAT, 11'h7FF};

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  scib_top uut (
    .clk_i              (clk),
    .rstn_i             (rstn),
    .host_i             (host_req),
    .rdata_o            (rdata),
    .frame_pulse_8khz_i (pin),
    .utopia_evt_i       (uto_evt),
    .utopia_hec_corr_i  (uto_corr),
    .tx_evt_i           (tx_evt),
    .rx_evt_i           (rx_evt),
    .rx_hec_corr_i      (rx_corr),
    .rx_port_en_i       (rx_en),
    .link_src_i         (src),
    .link_ovf_o         (ovf),
    .irq_n_o            (irq_n)
  );

  scib_host_model host (
    .clk_i   (clk),
    .host_o  (host_req),
    .rdata_i (rdata)
  );

  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [CNT_W-1:0] exp,
                       input logic [CNT_W-1:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic pulse(input int idx, input int n);
    repeat (n)
    begin
      @(posedge clk);
      #2;
      if (idx < 64)
        uto_evt[idx] = 1'b1;
      else if (idx < 96)
        tx_evt[idx-64] = 1'b1;
      else
        rx_evt[idx-96] = 1'b1;
      @(posedge clk);
      #2;
      uto_evt = '0;
      tx_evt = '0;
      rx_evt = '0;
    end
  endtask : pulse

  // pin pulse of the given width; edge detect plus sync needs 3 edges
  task automatic pin_pulse(input int n, input int width);
    repeat (n)
    begin
      @(posedge clk);
      #2;
      pin = 1'b1;
      repeat (width) @(posedge clk);
      #2;
      pin = 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : pin_pulse

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  // watchdog: the divide-by-8000 case dominates at about 40000 cycles
  initial
  begin
    #2000000;
    miscompares++;
    complete_run();
  end

  // ==========================================================
  // tests
  initial
  begin
    miscompares = 0;
    num_checks = 0;
    rstn = 1'b0;
    pin = 1'b0;
    uto_evt = '0;
    uto_corr = '0;
    tx_evt = '0;
    rx_evt = '0;
    rx_corr = '0;
    rx_en = '1;
    src = '0;
    repeat (4) @(posedge clk);
    #2;
    rstn = 1'b1;
    host.rd(ADDR_XFER_CMD, q);
    check("ready at reset", 24'h008000, 24'(q));
    foreach (zero_regs[i])
    begin
      host.rd(zero_regs[i], q);
      check("register at reset", 24'h000000, 24'(q));
    end
    host.cnt_read(143, v);
    check("counter at reset", 24'h000000, v);
    check("irq pin at reset", 24'h000001, 24'(irq_n));
    $display("test reset done");

    foreach (rows[i])
    begin
      host.cnt_load(rows[i].idx, rows[i].pre);
      pulse(rows[i].idx, rows[i].n);
      host.cnt_read(rows[i].idx, v);
      check("counter row", rows[i].exp, v);
    end
    $display("test table done");

    @(posedge clk);
    #2;
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    rstn = 1'b1;
    host.cnt_read(95, v);
    check("counter after reset", 24'h000000, v);
    uto_corr = 16'h0001;
    rx_corr = 16'h0001;
    pulse(3, 2);
    pulse(98, 2);
    uto_corr = '0;
    rx_corr = '0;
    rx_en = '0;
    pulse(96, 2);
    rx_en = '1;
    pulse(3, 1);
    host.cnt_read(3, v);
    check("corrected hec input", 24'h000001, v);
    host.cnt_read(98, v);
    check("corrected hec receive", 24'h000000, v);
    host.cnt_read(96, v);
    check("receive port disabled", 24'h000000, v);
    $display("test hec done");

    host.mask(0, 1'b1);
    host.cnt_load(0, 24'hFFFFFF);
    pulse(0, 1);
    check("overflow link flag", 24'h000001, 24'(ovf));
    host.rd(ADDR_MSTAT, q);
    check("master status", 24'h000001, 24'(q));
    check("irq pin not enabled", 24'h000001, 24'(irq_n));
    host.wr(ADDR_MEN, 16'h0001);
    check("irq pin enabled", 24'h000000, 24'(irq_n));
    host.rd(ADDR_MSTAT, q);
    host.wr(ADDR_MSTAT, 16'h0000);
    check("irq after status access", 24'h000000, 24'(irq_n));
    host.mask(0, 1'b0);
    check("masked flag", 24'h000000, 24'(ovf));
    check("masked irq pin", 24'h000001, 24'(irq_n));
    host.mask(0, 1'b1);
    check("flag held", 24'h000001, 24'(ovf));
    host.cnt_load(0, 24'h000000);
    check("flag cleared", 24'h000000, 24'(ovf));
    @(posedge clk);
    #2;
    src = 16'h0008;
    #1;
    check("source not enabled", 24'h000001, 24'(irq_n));
    host.wr(ADDR_MEN, 16'h0008);
    host.rd(ADDR_MSTAT, q);
    check("source status", 24'h000008, 24'(q));
    check("source irq pin", 24'h000000, 24'(irq_n));
    host.wr(ADDR_MEN, 16'h0000);
    check("enables cleared", 24'h000001, 24'(irq_n));
    host.wr(ADDR_MEN, 16'h0008);
    src = '0;
    #1;
    check("source removed", 24'h000001, 24'(irq_n));
    $display("test interrupt done");

    host.cnt_load(0, 24'h000010);
    host.cnt_read(0, v);
    pulse(0, 2);
    host.rd(ADDR_HOLD_LO, q);
    check("hold unchanged", 24'h000010, 24'(q));
    host.cnt_read(0, v);
    check("hold after read", 24'h000012, v);
    $display("test hold done");

    host.cnt_load(4, 24'h00FFFE);
    host.mask(4, 1'b1);
    host.set_cfg(16'h0100);
    pulse(4, 2);
    check("16 bit wrap", 24'h000002, 24'(ovf));
    pulse(64, 5);
    host.sw_latch();
    host.cnt_read(64, v);
    check("software latch", 24'h000005, v);
    pulse(64, 2);
    host.sw_latch();
    host.cnt_read(64, v);
    check("count since latch", 24'h000002, v);
    $display("test software latch done");

    host.set_cfg(16'h0700);
    pulse(96, 3);
    pin_pulse(7999, 2);
    host.cnt_read(96, v);
    check("before 8000th pulse", 24'h000000, v);
    pin_pulse(1, 2);
    host.cnt_read(96, v);
    check("8000th pulse", 24'h000003, v);
    host.set_cfg(16'h0300);
    pulse(96, 1);
    pin_pulse(1, 10);
    host.cnt_read(96, v);
    check("one latch per pulse", 24'h000001, v);
    $display("test pin latch done");
    complete_run();
  end
endmodule : tb_top

`default_nettype wire
